// ===== verilog/bdl_defines.vh
// constants for the branch likely resolution block
`ifndef BDL_DEFINES_VH
`define BDL_DEFINES_VH

// field positions inside the 32-bit instruction word
`define BDL_OP_HI        31
`define BDL_OP_LO        26
`define BDL_RS_HI        25
`define BDL_RS_LO        21
`define BDL_RT_HI        20
`define BDL_RT_LO        16
`define BDL_OFF_HI       15
`define BDL_OFF_LO       0

// major opcodes
`define BDL_OP_EQUAL_L   6'h14
`define BDL_OP_UNEQUAL_L 6'h15
`define BDL_OP_NONPOS_L  6'h16
`define BDL_OP_POS_L     6'h17
`define BDL_OP_REG_IMM   6'h01
`define BDL_OP_SYS_COP   6'h10

// sub-operation codes in the rt field of the register immediate opcode
`define BDL_SUB_NEG_L    5'h02
`define BDL_SUB_NNEG_L   5'h03
`define BDL_SUB_NEG_LL   5'h12
`define BDL_SUB_NNEG_LL  5'h13

// rs field selecting the condition-branch group of the system coprocessor
`define BDL_COP_BC       5'h08
// rt field condition selectors of the system coprocessor branch
`define BDL_COP_FALSE_L  5'h02
`define BDL_COP_TRUE_L   5'h03

// condition selectors
`define BDL_CND_EQ       3'h0
`define BDL_CND_NE       3'h1
`define BDL_CND_LEZ      3'h2
`define BDL_CND_GTZ      3'h3
`define BDL_CND_LTZ      3'h4
`define BDL_CND_GEZ      3'h5
`define BDL_CND_CPT      3'h6
`define BDL_CND_CPF      3'h7

// link register index and address steps in bytes
`define BDL_LINK_REG     5'h1F
`define BDL_STEP_SLOT    64'h0000_0000_0000_0004
`define BDL_STEP_LINK    64'h0000_0000_0000_0008

`endif

// ===== verilog/bdl_decode.v
// instruction decoder for the branch likely group
`timescale 1ns/1ps
`include "bdl_defines.vh"

module bdl_decode (
    input  wire [31:0] i_instr,
    output reg         o_hit,
    output reg  [2:0]  o_cond,
    output reg         o_link
);

    wire [5:0] op;
    wire [4:0] rs;
    wire [4:0] rt;

    assign op = i_instr[`BDL_OP_HI:`BDL_OP_LO];
    assign rs = i_instr[`BDL_RS_HI:`BDL_RS_LO];
    assign rt = i_instr[`BDL_RT_HI:`BDL_RT_LO];

    always @* begin
        o_hit  = 1'b0;
        o_cond = `BDL_CND_EQ;
        o_link = 1'b0;
        case (op)
            `BDL_OP_EQUAL_L: begin
                o_hit  = 1'b1;
                o_cond = `BDL_CND_EQ;
            end
            `BDL_OP_UNEQUAL_L: begin
                o_hit  = 1'b1;
                o_cond = `BDL_CND_NE;
            end
            `BDL_OP_NONPOS_L: begin
                o_hit  = 1'b1;
                o_cond = `BDL_CND_LEZ;
            end
            `BDL_OP_POS_L: begin
                o_hit  = 1'b1;
                o_cond = `BDL_CND_GTZ;
            end
            `BDL_OP_REG_IMM: begin
                case (rt)
                    `BDL_SUB_NEG_L: begin
                        o_hit  = 1'b1;
                        o_cond = `BDL_CND_LTZ;
                    end
                    `BDL_SUB_NNEG_L: begin
                        o_hit  = 1'b1;
                        o_cond = `BDL_CND_GEZ;
                    end
                    `BDL_SUB_NEG_LL: begin
                        o_hit  = 1'b1;
                        o_cond = `BDL_CND_LTZ;
                        o_link = 1'b1;
                    end
                    `BDL_SUB_NNEG_LL: begin
                        o_hit  = 1'b1;
                        o_cond = `BDL_CND_GEZ;
                        o_link = 1'b1;
                    end
                    default: begin
                        o_hit  = 1'b0;
                    end
                endcase
            end
            `BDL_OP_SYS_COP: begin
                if (rs == `BDL_COP_BC && rt == `BDL_COP_TRUE_L) begin
                    o_hit  = 1'b1;
                    o_cond = `BDL_CND_CPT;
                end else if (rs == `BDL_COP_BC && rt == `BDL_COP_FALSE_L) begin
                    o_hit  = 1'b1;
                    o_cond = `BDL_CND_CPF;
                end
            end
            default: begin
                o_hit  = 1'b0;
            end
        endcase
    end

endmodule

// ===== verilog/bdl_branch_likely.v
// branch likely resolution between register fetch and instruction fetch
//
// Overview of operation
// RULE1 - equal likely branch taken on equal operands
// RULE2 - unequal likely branch taken on differing operands
// RULE3 - nonpositive likely branch on signed zero/negative
// RULE4 - positive likely branch only on strictly positive
// RULE5 - sign tests: negative, or non-negative, branches
// RULE6 - link forms write return address to register 31
// RULE7 - coprocessor true form branches on condition high
// RULE8 - coprocessor false form branches on condition low
// RULE9 - target: slot address plus shifted extended offset
// RULE10 - redirect only after exactly one delay slot
// RULE11 - failed condition cancels slot, continue sequentially
// RULE12 - non-likely branches never cancel their slot
// RULE13 - resolve across register fetch into execute
// RULE14 - link written whether or not branch taken
`timescale 1ns/1ps
`include "bdl_defines.vh"

module bdl_branch_likely (
    input  wire        i_clk,
    input  wire        i_srst,
    input  wire        i_rf_valid,
    input  wire [31:0] i_rf_instr,
    input  wire [63:0] i_rf_pc,
    input  wire [63:0] i_rs_val,
    input  wire [63:0] i_rt_val,
    input  wire        i_cop_cond,
    output wire        o_busy,
    output reg         o_redirect,
    output reg  [63:0] o_target,
    output reg         o_nullify,
    output reg         o_link_we,
    output reg  [4:0]  o_link_idx,
    output reg  [63:0] o_link_data
);

    ////////////////////////////////////////////////////////////////////////
    // resolution states

    localparam ST_IDLE    = 1'b0;
    localparam ST_RESOLVE = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function is_negative;
        input [63:0] val;
        begin
            is_negative = val[63];
        end
    endfunction

    function is_zero;
        input [63:0] val;
        begin
            is_zero = (val == 64'h0000_0000_0000_0000);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decode in register fetch

    wire       dec_hit;
    wire [2:0] dec_cond;
    wire       dec_link;

    bdl_decode u_decode (
        .i_instr (i_rf_instr),
        .o_hit   (dec_hit),
        .o_cond  (dec_cond),
        .o_link  (dec_link)
    );

    reg        state;
    reg        next_state;
    reg        taken;
    reg        next_taken;
    reg [63:0] target;
    reg [63:0] next_target;
    reg        cond_met;
    reg        slot_here;
    reg        accept;

    wire [63:0] slot_addr;
    wire [63:0] offset_ext;
    wire [63:0] link_addr;

    // RULE9 target arithmetic
    assign offset_ext = {{46{i_rf_instr[`BDL_OFF_HI]}},
                         i_rf_instr[`BDL_OFF_HI:`BDL_OFF_LO], 2'b00};
    assign slot_addr  = i_rf_pc + `BDL_STEP_SLOT;
    // RULE6 return address past slot
    assign link_addr  = i_rf_pc + `BDL_STEP_LINK;

    always @* begin
        cond_met = 1'b0;
        case (dec_cond)
            // RULE1 equal compare
            `BDL_CND_EQ:  cond_met = (i_rs_val == i_rt_val);
            // RULE2 unequal compare
            `BDL_CND_NE:  cond_met = (i_rs_val != i_rt_val);
            // RULE3 zero or negative
            `BDL_CND_LEZ: cond_met = is_negative(i_rs_val) | is_zero(i_rs_val);
            // RULE4 strictly positive only
            `BDL_CND_GTZ: cond_met = ~is_negative(i_rs_val) & ~is_zero(i_rs_val);
            // RULE5 sign test forms
            `BDL_CND_LTZ: cond_met = is_negative(i_rs_val);
            `BDL_CND_GEZ: cond_met = ~is_negative(i_rs_val);
            // RULE7 coprocessor condition high
            `BDL_CND_CPT: cond_met = i_cop_cond;
            // RULE8 coprocessor condition low
            `BDL_CND_CPF: cond_met = ~i_cop_cond;
            default:      cond_met = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // resolution sequencing

    always @* begin
        // the slot instruction occupies register fetch while branch is in execute
        slot_here   = (state == ST_RESOLVE) & i_rf_valid;
        // a cancelled slot must never be decoded as a new branch
        accept      = i_rf_valid & dec_hit & (state == ST_IDLE);
        next_state  = state;
        next_taken  = taken;
        next_target = target;
        case (state)
            ST_IDLE: begin
                // RULE13 latch compare result into execute
                if (accept) begin
                    next_state  = ST_RESOLVE;
                    next_taken  = cond_met;
                    next_target = slot_addr + offset_ext;
                end
            end
            ST_RESOLVE: begin
                // RULE10 wait for exactly one slot
                if (slot_here) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            state  <= ST_IDLE;
            taken  <= 1'b0;
            target <= 64'h0000_0000_0000_0000;
        end else begin
            state  <= next_state;
            taken  <= next_taken;
            target <= next_target;
        end
    end

    assign o_busy = (state == ST_RESOLVE);

    // link forms write their return address as soon as they are accepted
    wire link_now;
    assign link_now = accept & dec_link;

    ////////////////////////////////////////////////////////////////////////
    // outputs toward fetch, the slot and the register file

    // RULE10 redirect once slot has passed
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_redirect <= 1'b0;
        end else begin
            o_redirect <= slot_here & taken;
        end
    end

    // RULE9 target held for fetch
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_target <= 64'h0000_0000_0000_0000;
        end else if (slot_here) begin
            o_target <= target;
        end
    end

    // RULE11 cancel slot on failed condition
    // RULE12 only likely forms are ever decoded here
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_nullify <= 1'b0;
        end else begin
            o_nullify <= slot_here & ~taken;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link register write

    // RULE14 link written regardless of outcome
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_link_we <= 1'b0;
        end else begin
            o_link_we <= link_now;
        end
    end

    // RULE6 index of register 31
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_link_idx <= 5'h00;
        end else if (link_now) begin
            o_link_idx <= `BDL_LINK_REG;
        end
    end

    // RULE6 return address past slot
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_link_data <= 64'h0000_0000_0000_0000;
        end else if (link_now) begin
            o_link_data <= link_addr;
        end
    end

endmodule

// ===== verilog/bdl_unused_placeholder_none.v
// no design content lives in this file

// ===== sim/bdl_branch_likely_asserts.sv
// assertion checker for the branch likely resolution block
`timescale 1ns/1ps
module bdl_chk (
    input wire        i_clk,
    input wire        i_srst,
    input wire        i_rf_valid,
    input wire [31:0] i_rf_instr,
    input wire [63:0] i_rf_pc,
    input wire [63:0] i_rs_val,
    input wire [63:0] i_rt_val,
    input wire        i_cop_cond,
    input wire        o_busy,
    input wire        o_redirect,
    input wire [63:0] o_target,
    input wire        o_nullify,
    input wire        o_link_we,
    input wire [4:0]  o_link_idx,
    input wire [63:0] o_link_data
);
    wire [5:0]  op = i_rf_instr[31:26];
    wire [4:0]  rt = i_rf_instr[20:16];
    wire        lk = op == 6'h01 && rt[4:1] == 4'h9;
    wire        lb = i_rf_valid && !o_busy && (op[5:2] == 4'h5
                || op == 6'h01 && rt[3:1] == 3'h1
                || op == 6'h10 && i_rf_instr[25:21] == 5'h08 && rt[4:1] == 4'h1);
    reg  [63:0] exp_tgt;
    // target seen from the slot address
    always @(posedge i_clk)
        if (lb)
            exp_tgt <= i_rf_pc + 64'h4 + {{46{i_rf_instr[15]}}, i_rf_instr[15:0], 2'b00};
    ////////////////////////////////////////////////////////////
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence s_take; lb; endsequence
    sequence s_slot; o_busy && i_rf_valid; endsequence
    chk_take_busy: assert property (s_take |=> o_busy)
        else $error("busy missing after branch");
    chk_slot_resolve: assert property (
        s_slot |=> (o_redirect ^ o_nullify) && !o_busy)
        else $error("slot not resolved");
    chk_slot_wait: assert property (
        o_busy && !i_rf_valid |=> o_busy && !o_redirect && !o_nullify)
        else $error("resolved without slot");
    chk_no_stray: assert property (
        !(o_busy && i_rf_valid) |=> !o_redirect && !o_nullify)
        else $error("stray redirect or cancel");
    chk_link_write: assert property (
        s_take ##0 lk |=> o_link_we && o_link_data == $past(i_rf_pc) + 64'h8)
        else $error("link write wrong");
    chk_link_only: assert property (!(lb && lk) |=> !o_link_we)
        else $error("link write without link branch");
    chk_link_idx: assert property (o_link_we |-> o_link_idx == 5'h1F)
        else $error("link index not 31");
    chk_target_val: assert property (o_redirect |-> o_target == exp_tgt)
        else $error("target wrong");
endmodule

// ===== sim/branch_likely_resolution_test.sv
// self-checking testbench for the branch likely resolution block
`timescale 1ns/1ps
module branch_likely_resolution_test;
    reg         i_clk = 1'b0;
    reg         i_srst = 1'b1;
    reg         i_rf_valid = 1'b0;
    reg  [31:0] i_rf_instr = 32'h0000_0000;
    reg  [63:0] i_rf_pc = 64'h0;
    reg  [63:0] i_rs_val = 64'h0;
    reg  [63:0] i_rt_val = 64'h0;
    reg         i_cop_cond = 1'b0;
    wire        o_busy;
    wire        o_redirect;
    wire [63:0] o_target;
    wire        o_nullify;
    wire        o_link_we;
    wire [4:0]  o_link_idx;
    wire [63:0] o_link_data;
    integer     miscompares = 0;
    integer     check_count = 0;
    integer     k;
    integer     j;
    reg  [63:0] rnd = 64'h2;
    reg  [63:0] a;
    // likely forms 0..9, then plain branch, plain sign test, plain link
    localparam [415:0] OPS = {32'h0410_0000, 32'h0400_0000, 32'h1000_0000,
        32'h4102_0000, 32'h4103_0000, 32'h0413_0000, 32'h0412_0000,
        32'h0403_0000, 32'h0402_0000, 32'h5C00_0000, 32'h5800_0000,
        32'h5400_0000, 32'h5000_0000};

    bdl_branch_likely uut (
        .i_clk       (i_clk),
        .i_srst      (i_srst),
        .i_rf_valid  (i_rf_valid),
        .i_rf_instr  (i_rf_instr),
        .i_rf_pc     (i_rf_pc),
        .i_rs_val    (i_rs_val),
        .i_rt_val    (i_rt_val),
        .i_cop_cond  (i_cop_cond),
        .o_busy      (o_busy),
        .o_redirect  (o_redirect),
        .o_target    (o_target),
        .o_nullify   (o_nullify),
        .o_link_we   (o_link_we),
        .o_link_idx  (o_link_idx),
        .o_link_data (o_link_data)
    );

    initial begin
        forever #50 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////
    function [63:0] lfsr(input [63:0] x);
        lfsr = {x[62:0], x[63] ^ x[62] ^ x[60] ^ x[59]};
    endfunction

    // slot address plus the shifted, sign-extended offset
    function [63:0] exp_target(input [63:0] p, input [15:0] o);
        exp_target = p + 64'h4 + {{46{o[15]}}, o, 2'b00};
    endfunction

    function want(input [31:0] i, input [63:0] s, input [63:0] t, input c);
        case (i[31:26])
            6'h14: want = s == t;
            6'h15: want = s != t;
            6'h16: want = $signed(s) <= 0;
            6'h17: want = $signed(s) > 0;
            6'h01: want = s[63] ^ i[16];
            default: want = c ^ ~i[16];
        endcase
    endfunction

    task chk(input [8*6-1:0] nm, input [63:0] e, input [63:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("[ERR] %0s exp %h got %h", nm, e, g);
            end
        end
    endtask

    task finish_test;
        begin
            $display("checks %0d mismatches %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    task run(input integer n, input [63:0] pc, input [63:0] s, input [63:0] t,
             input c, input [15:0] off, input integer gap);
        reg [31:0] ins;
        reg        li;
        reg        tk;
        reg        lk;
        integer    m;
        begin
            ins = OPS[n*32 +: 32] | {16'h0000, off};
            li = n < 10;
            tk = want(ins, s, t, c);
            lk = n == 6 || n == 7;
            @(posedge i_clk);
            i_rf_valid <= 1'b1;
            i_rf_instr <= ins;
            i_rf_pc <= pc;
            i_rs_val <= s;
            i_rt_val <= t;
            i_cop_cond <= c;
            @(posedge i_clk);
            // slot carries a branch word, flipped rs value and flipped coprocessor condition
            i_rf_valid <= gap == 0;
            i_rf_pc <= pc + 64'h4;
            i_rs_val <= ~s;
            i_cop_cond <= ~c;
            #1;
            chk("issue", {li, lk}, {o_busy, o_link_we});
            if (lk) chk("link", pc + 64'h8, o_link_data);
            if (lk) chk("idx", 64'h1F, o_link_idx);
            for (m = 1; m <= gap; m = m + 1) begin
                @(posedge i_clk);
                i_rf_valid <= m == gap;
                #1;
                chk("wait", {li, 1'b0}, {o_busy, o_nullify | o_redirect});
            end
            @(posedge i_clk);
            i_rf_valid <= 1'b0;
            #1;
            chk("redir", li & tk, o_redirect);
            chk("null", li & ~tk, o_nullify);
            chk("idle", 1'b0, o_busy);
            if (li & tk) chk("target", exp_target(pc, off), o_target);
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        #2_000_000;
        miscompares = miscompares + 1;
        $display("[ERR] watchdog exp done got hang");
        finish_test;
    end

    initial begin
        repeat (10) @(posedge i_clk);
        i_srst <= 1'b0;
        #1;
        chk("rst", 64'h0, {o_busy, o_redirect, o_nullify, o_link_we, o_link_idx});
        chk("rsttgt", 64'h0, o_target);
        $display("test reset done");
        for (k = 0; k < 52; k = k + 1) begin
            j = k / 13;
            a = j == 0 ? 64'h0 : j == 1 ? 64'h1 : j == 2 ? 64'h8000_0000_0000_0000 : ~64'h0;
            run(k % 13, 64'hFFFF_FFFF_FFFF_FFF0, a, j[0] ? ~a : a, j[0],
                j == 1 ? 16'h7FFF : 16'h8000, j);
        end
        $display("test corners done");
        for (k = 0; k < 300; k = k + 1) begin
            rnd = lfsr(rnd);
            a = rnd;
            rnd = lfsr(rnd);
            run(a % 13, {a[63:2], 2'b00}, rnd, a[5] ? rnd : a, a[6], a[31:16], a[8:7]);
        end
        $display("test random done");
        @(posedge i_clk);
        i_rf_valid <= 1'b1;
        i_rf_instr <= 32'h5000_0000;
        @(posedge i_clk);
        i_srst <= 1'b1;
        i_rf_valid <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_srst <= 1'b0;
        #1;
        chk("rst2", 64'h0, {o_busy, o_nullify, o_redirect});
        run(0, 64'h100, 64'h5, 64'h5, 1'b0, 16'h0010, 0);
        $display("test midreset done");
        finish_test;
    end
endmodule

bind bdl_branch_likely bdl_chk u_chk (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_rf_valid  (i_rf_valid),
    .i_rf_instr  (i_rf_instr),
    .i_rf_pc     (i_rf_pc),
    .i_rs_val    (i_rs_val),
    .i_rt_val    (i_rt_val),
    .i_cop_cond  (i_cop_cond),
    .o_busy      (o_busy),
    .o_redirect  (o_redirect),
    .o_target    (o_target),
    .o_nullify   (o_nullify),
    .o_link_we   (o_link_we),
    .o_link_idx  (o_link_idx),
    .o_link_data (o_link_data)
);
